// [hdl/pitc_compare.v]
// one event-timer comparator with its enable
// assumes timer and compare value on mclk
module pitc_compare #(
    parameter WIDTH = 24
) (
    input wire mclk,
    input wire rst,
    input wire enable,
    input wire [WIDTH-1:0] timer,
    input wire [WIDTH-1:0] compare,
    output reg hit
);
    reg [WIDTH-1:0] timer_last;
    // a hit is a fresh match: timer just moved onto the compare value
    always @(posedge mclk) begin
        if (rst) begin
            timer_last <= {WIDTH{1'b0}};
            hit <= 1'b0;
        end else begin
            timer_last <= timer;
            hit <= enable && (timer == compare) && (timer != timer_last);
        end
    end
endmodule

// [hdl/pitc_regs.vh]
// register offsets, field positions and reset values of the phy control bank
// assumes an 8-bit register port with a 7-bit address, as on the command channel
`ifndef PITC_REGS_VH
`define PITC_REGS_VH
`define PITC_ADDR_CTRL_TIMER 7'h05
`define PITC_ADDR_FRAME_LEN 7'h06
`define PITC_ADDR_CTRL_FILTER 7'h07
`define PITC_ADDR_STATUS 7'h10
`define PITC_RST_CTRL_TIMER 8'h06
`define PITC_RST_CTRL_FILTER 8'h08
`define PITC_WMASK_CTRL_TIMER 8'hf7
`define PITC_WMASK_CTRL_FILTER 8'hfb
`define PITC_BIT_T1EN 4
`define PITC_BIT_T2EN 5
`define PITC_BIT_T3EN 6
`define PITC_BIT_T4EN 7
`define PITC_BIT_SECMSK 2
`define PITC_BIT_PBMSK 1
`define PITC_BIT_WAKEMSK 0
`define PITC_BIT_GMSK 7
`define PITC_BIT_T3ABORT 6
`define PITC_BIT_COORD 5
`define PITC_BIT_CCAHI 4
`define PITC_BIT_CCALO 3
`define PITC_BIT_LOAD 2
`define PITC_BIT_PROMISC 1
`define PITC_BIT_T2SEC 0
`define PITC_LEN_MIN 7'h05
`define PITC_LEN_MAX 7'h7f
`define PITC_CCA_ED 2'h0
`define PITC_CCA_MODE1 2'h1
`define PITC_CCA_MODE2 2'h2
`define PITC_CCA_MODE3 2'h3
`endif

// [hdl/pitc_top.v]
// phy control bank: comparator enables, interrupt masks, filter and cca control
// assumes a byte register port on mclk and event sources on mclk
module pitc_top #(
    parameter TW = 24
) (
    // clock and reset
    input wire mclk,
    input wire rst,
    // register port
    input wire [6:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // event timer and compare values
    input wire [TW-1:0] event_timer,
    input wire [TW-1:0] first_compare_value,
    input wire [TW-1:0] second_compare_value,
    input wire [TW-1:0] third_compare_value,
    input wire [TW-1:0] fourth_compare_value,
    input wire [15:0] secondary_compare2_value,
    output reg timer_load,
    output reg [TW-1:0] timer_load_value,
    // event sources as one-cycle pulses, frame length, and the op_busy level
    input wire aes_event,
    input wire pb_error_event,
    input wire wake_event,
    input wire rx_frame_done,
    input wire [6:0] rx_frame_length,
    input wire op_busy,
    // filter inputs for the frame under test
    input wire filt_check,
    input wire [6:0] filt_length,
    input wire filt_normal_pass,
    input wire filt_has_dest,
    input wire filt_src_pan_match,
    // controls to the rest of the phy
    output reg [1:0] channel_assessment_type,
    output reg filt_accept,
    output reg op_abort,
    // interrupt request, active low
    output reg irq_n
);
    `include "pitc_regs.vh"

    reg [7:0] ctrl_timer;
    reg [7:0] ctrl_filter;
    reg [6:0] frame_len;
    // status: 0 t1, 1 t2, 2 t3, 3 t4, 4 aes, 5 pb error, 6 wake
    reg [6:0] status;
    reg load_last;
    reg [7:0] next_rdata;
    reg [TW-1:0] t2_last;
    wire [3:0] cmp_hit;
    wire [TW-1:0] cmp_val [0:3];
    wire t2_sec_hit;
    wire [6:0] evt;
    wire [6:0] clr;
    wire [6:0] unmasked;
    wire wr_timer;
    wire wr_filter;
    wire load_bit;

    assign cmp_val[0] = first_compare_value;
    assign cmp_val[1] = second_compare_value;
    assign cmp_val[2] = third_compare_value;
    assign cmp_val[3] = fourth_compare_value;

    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_cmp
            // enables sit in bits 4..7, first to fourth
            pitc_compare #(.WIDTH(TW)) u_cmp (
                .mclk(mclk),
                .rst(rst),
                .enable(ctrl_timer[`PITC_BIT_T1EN + i]),
                .timer(event_timer),
                .compare(cmp_val[i]),
                .hit(cmp_hit[i])
            );
        end
    endgenerate

    always @(posedge mclk) begin
        if (rst) begin
            t2_last <= {TW{1'b0}};
        end else begin
            t2_last <= event_timer;
        end
    end
    // fresh match on the low half: the whole timer moved, as for the comparators
    assign t2_sec_hit = ctrl_filter[`PITC_BIT_T2SEC]
        && (event_timer[15:0] == secondary_compare2_value)
        && (event_timer != t2_last);

    assign evt = {wake_event, pb_error_event, aes_event, cmp_hit[3], cmp_hit[2],
                  cmp_hit[1] | t2_sec_hit, cmp_hit[0]};
    assign wr_timer = reg_wr && (reg_addr == `PITC_ADDR_CTRL_TIMER);
    assign wr_filter = reg_wr && (reg_addr == `PITC_ADDR_CTRL_FILTER);
    assign clr = (reg_wr && (reg_addr == `PITC_ADDR_STATUS)) ? reg_wdata[6:0] : 7'h00;
    assign load_bit = wr_filter && reg_wdata[`PITC_BIT_LOAD];

    // control registers; load bit never stored, so it reads zero
    always @(posedge mclk) begin
        if (rst) begin
            ctrl_timer <= `PITC_RST_CTRL_TIMER;
            ctrl_filter <= `PITC_RST_CTRL_FILTER;
            load_last <= 1'b0;
        end else begin
            if (wr_timer) begin
                ctrl_timer <= reg_wdata & `PITC_WMASK_CTRL_TIMER;
            end
            if (wr_filter) begin
                ctrl_filter <= reg_wdata & `PITC_WMASK_CTRL_FILTER;
                load_last <= reg_wdata[`PITC_BIT_LOAD];
            end
        end
    end

    // timer load on a low-to-high write of the load bit
    always @(posedge mclk) begin
        if (rst) begin
            timer_load <= 1'b0;
            timer_load_value <= {TW{1'b0}};
        end else begin
            timer_load <= load_bit && !load_last;
            timer_load_value <= first_compare_value;
        end
    end

    // sticky status: set wins over clear, masks never stop the set
    always @(posedge mclk) begin
        if (rst) begin
            status <= 7'h00;
        end else begin
            status <= (status & ~clr) | evt;
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            frame_len <= 7'h00;
        end else if (rx_frame_done) begin
            frame_len <= rx_frame_length;
        end
    end

    assign unmasked = {
        ~ctrl_timer[`PITC_BIT_WAKEMSK],
        ~ctrl_timer[`PITC_BIT_PBMSK],
        ~ctrl_timer[`PITC_BIT_SECMSK],
        4'hf};

    always @(posedge mclk) begin
        if (rst) begin
            irq_n <= 1'b1;
        end else begin
            irq_n <= ~(|(status & unmasked) && !ctrl_filter[`PITC_BIT_GMSK]);
        end
    end

    // third timer event aborts receive or cca only when enabled
    always @(posedge mclk) begin
        if (rst) begin
            op_abort <= 1'b0;
        end else begin
            op_abort <= ctrl_filter[`PITC_BIT_T3ABORT] && cmp_hit[2] && op_busy;
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            channel_assessment_type <= `PITC_CCA_MODE1;
        end else begin
            channel_assessment_type <= {ctrl_filter[`PITC_BIT_CCAHI],
                                        ctrl_filter[`PITC_BIT_CCALO]};
        end
    end

    // receive filter decision
    always @(posedge mclk) begin
        if (rst) begin
            filt_accept <= 1'b0;
        end else if (!filt_check) begin
            filt_accept <= 1'b0;
        end else if (filt_length < `PITC_LEN_MIN || filt_length > `PITC_LEN_MAX) begin
            filt_accept <= 1'b0;
        end else if (ctrl_filter[`PITC_BIT_PROMISC]) begin
            filt_accept <= 1'b1;
        end else if (!filt_has_dest) begin
            filt_accept <= ctrl_filter[`PITC_BIT_COORD] && filt_src_pan_match;
        end else begin
            filt_accept <= filt_normal_pass;
        end
    end

    always @* begin
        case (reg_addr)
            `PITC_ADDR_CTRL_TIMER: next_rdata = ctrl_timer;
            `PITC_ADDR_FRAME_LEN: next_rdata = {1'b0, frame_len};
            `PITC_ADDR_CTRL_FILTER: next_rdata = ctrl_filter;
            `PITC_ADDR_STATUS: next_rdata = {1'b0, status};
            default: next_rdata = 8'h00;
        endcase
    end

    always @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end
endmodule

// [sim/phy_irq_timer_control_regs_tb_top.sv]
// self-checking bench for the phy control bank
// assumes pitc_host on the register port and the bound checker
module phy_irq_timer_control_regs_tb_top;
    timeunit 1ns / 1ns;
    logic mclk, rst, reg_wr, reg_rd, timer_load, aes_event, pb_error_event, wake_event;
    logic rx_frame_done, op_busy, filt_check, filt_normal_pass, filt_has_dest;
    logic filt_src_pan_match, filt_accept, op_abort, irq_n, ab_seen;
    logic [1:0] channel_assessment_type;
    logic [6:0] reg_addr, rx_frame_length, filt_length;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic [15:0] secondary_compare2_value;
    logic [23:0] event_timer, first_compare_value, second_compare_value;
    logic [23:0] third_compare_value, fourth_compare_value, timer_load_value;
    int errors, cmp_count, cyc, i;
    pitc_host host_u (.*);
    pitc_top #(.TW(24)) dut_u (.*);
    always #10 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (op_abort === 1'b1)
            ab_seen <= 1'b1;
        if (cyc == 3000) begin
            errors++;
            stop_test();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        if (errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        host_u.acc(1'b1, a, v, d);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        host_u.acc(1'b0, a, 8'h00, d);
        chk(d, e);
    endtask
    task automatic step(input logic [23:0] v);
        event_timer <= v;
        tick(4);
    endtask
    task automatic pulse(input logic [2:0] v);
        {aes_event, pb_error_event, wake_event} <= v;
        tick(1);
        {aes_event, pb_error_event, wake_event} <= 3'b000;
        tick(3);
    endtask
    task automatic filt(input logic [6:0] l, input logic [2:0] f, input logic e);
        {filt_check, filt_length} <= {1'b1, l};
        {filt_normal_pass, filt_has_dest, filt_src_pan_match} <= f;
        tick(2);
        chk(filt_accept, e);
        filt_check <= 1'b0;
        tick(1);
    endtask
    initial begin
        {mclk, aes_event, pb_error_event, wake_event, rx_frame_done, op_busy, ab_seen} = '0;
        {filt_check, filt_normal_pass, filt_has_dest, filt_src_pan_match} = '0;
        {rx_frame_length, filt_length, event_timer, cyc} = '0;
        {first_compare_value, second_compare_value} = {24'h000010, 24'h000020};
        {third_compare_value, fourth_compare_value} = {24'h000030, 24'h000040};
        secondary_compare2_value = 16'h0050;
        rst = 1'b1;
        tick(4);
        rst <= 1'b0;
        rd(7'h05, 8'h06);
        rd(7'h07, 8'h08);
        chk(irq_n, 1'b1);
        rd(7'h20, 8'h00);
        wr(7'h05, 8'hff);
        rd(7'h05, 8'hf7);
        for (i = 0; i < 2; i++) begin
            wr(7'h05, i ? 8'hf6 : 8'h06);
            for (int k = 1; k < 5; k++)
                step(24'(16 * k));
            step(24'hab0050);
            rd(7'h10, i ? 8'h0f : 8'h00);
            chk(irq_n, !i);
        end
        wr(7'h07, 8'h88);
        tick(2);
        chk(irq_n, 1'b1);
        wr(7'h07, 8'h09);
        wr(7'h05, 8'h06);
        wr(7'h10, 8'h7f);
        step(24'h120050);
        rd(7'h10, 8'h02);
        wr(7'h10, 8'h7f);
        pulse(3'b110);
        chk(irq_n, 1'b1);
        rd(7'h10, 8'h30);
        pulse(3'b001);
        chk(irq_n, 1'b0);
        {rx_frame_done, rx_frame_length} <= {1'b1, 7'h7f};
        tick(1);
        rx_frame_done <= 1'b0;
        wr(7'h06, 8'h11);
        rd(7'h06, 8'h7f);
        wr(7'h07, 8'h0c);
        chk(timer_load, 1'b1);
        chk(timer_load_value[7:0], 8'h10);
        rd(7'h07, 8'h08);
        wr(7'h07, 8'h0c);
        chk(timer_load, 1'b0);
        for (i = 0; i < 4; i++) begin
            wr(7'h07, 8'(i << 3));
            tick(1);
            chk(channel_assessment_type, 8'(i));
        end
        filt(7'd20, 3'b110, 1'b1);
        filt(7'd4, 3'b111, 1'b0);
        filt(7'd20, 3'b101, 1'b0);
        wr(7'h07, 8'h20);
        filt(7'd20, 3'b001, 1'b1);
        filt(7'd20, 3'b000, 1'b0);
        wr(7'h07, 8'h02);
        filt(7'd127, 3'b000, 1'b1);
        filt(7'd5, 3'b000, 1'b1);
        filt(7'd4, 3'b000, 1'b0);
        op_busy <= 1'b1;
        wr(7'h05, 8'h46);
        step(24'h000030);
        chk(ab_seen, 1'b0);
        wr(7'h07, 8'h48);
        step(24'h000000);
        step(24'h000030);
        chk(ab_seen, 1'b1);
        stop_test();
    end
endmodule

// [sim/pitc_asserts.sv]
// port checker for the phy control bank
// assumes binding into pitc_top; helpers mirror control writes
module pitc_asserts #(
    parameter TW = 24
) (
    // clock, reset and register port
    input wire logic mclk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    // timer and events
    input wire logic [TW-1:0] event_timer,
    input wire logic [TW-1:0] first_compare_value,
    input wire logic [TW-1:0] third_compare_value,
    input wire logic [TW-1:0] timer_load_value,
    input wire logic timer_load,
    input wire logic op_busy,
    input wire logic op_abort,
    input wire logic wake_event,
    // filter and outputs
    input wire logic filt_check,
    input wire logic filt_accept,
    input wire logic irq_n,
    input wire logic [6:0] filt_length,
    input wire logic [1:0] channel_assessment_type
);
    timeunit 1ns / 1ns;
    logic [7:0] r5, r7;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    always @(posedge mclk) begin
        if (rst) begin
            r5 <= 8'h06;
            r7 <= 8'h08;
        end else if (reg_wr && reg_addr == 7'h05) begin
            r5 <= reg_wdata;
        end else if (reg_wr && reg_addr == 7'h07) begin
            r7 <= reg_wdata;
        end
    end
    load_pulse_a: assert property (reg_wr && reg_addr == 7'h07 && reg_wdata[2] && !r7[2]
        |=> timer_load && timer_load_value == $past(first_compare_value)) else $error("no load");
    global_mask_a: assert property (r7[7] && $past(r7[7]) |-> irq_n) else $error("irq");
    wake_irq_a: assert property (wake_event && !r5[0] && !r7[7] |-> ##[1:3] !irq_n)
        else $error("no irq");
    abort_off_a: assert property (!r7[6] [*3] |-> !op_abort) else $error("abort");
    abort_on_a: assert property ($changed(event_timer) && event_timer == third_compare_value
        && r5[6] && r7[6] && op_busy |-> ##[1:3] op_abort) else $error("no abort");
    // the type output lags the register by one edge
    cca_type_a: assert property (channel_assessment_type == $past(r7[4:3]))
        else $error("cca");
    short_frame_a: assert property (filt_check && filt_length < 7'h05 |=> !filt_accept)
        else $error("short");
    promisc_pass_a: assert property (filt_check && r7[1] && filt_length >= 7'h05 |=> filt_accept)
        else $error("promisc");
endmodule
bind pitc_top pitc_asserts #(.TW(TW)) chk_u (.*);

// [sim/pitc_host.sv]
// host model for the phy control bank register port
// assumes a request is taken on the edge where reg_wr or reg_rd is high
module pitc_host (
    // clock
    input wire logic mclk,
    // register port
    output logic [6:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns / 1ns;
    initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    // released address and data lines carry the inverse of their last value; reg_wr and reg_rd go low
    task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] wd,
        output logic [7:0] d);
        @(posedge mclk);
        {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, wd, w, !w};
        @(posedge mclk);
        {reg_addr, reg_wdata, reg_wr, reg_rd} <= {~a, ~wd, 2'b00};
        @(posedge mclk);
        d = reg_rdata;
    endtask
endmodule
